// ---- rtl/pcct_debounce.sv ----
`timescale 1ns/1ps
module pcct_debounce import pcct_pkg::*; #(
	parameter int PRESC = PRESC_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Synchronised raw levels: warm, adapter, ring, wake
	input wire logic [3:0] raw_n,
	input wire logic trigger,
	input wire logic [2:0] sel,
	// Debounced levels and observation
	output logic [3:0] level_n,
	output logic obs_bit,
	output logic presc_bit
);
	logic [PRESC_W-1:0] presc_q;
	logic [PRESC_W-1:0] presc_d;
	logic [DB_CNT_W-1:0] cnt_q [4];
	logic [DB_CNT_W-1:0] cnt_d [4];
	logic [3:0] lvl_q;
	logic [3:0] lvl_d;
	logic obs_q;
	logic obs_d;
	logic tick;

	// Trigger lets test software step the counters every clock
	always_comb begin
		tick = trigger || (presc_q == PRESC_W'(PRESC - 1));
		presc_d = tick ? '0 : presc_q + PRESC_W'(1);
		lvl_d = lvl_q;
		for (int i = 0; i < 4; i++) begin
			cnt_d[i] = cnt_q[i];
			if (raw_n[i] == lvl_q[i]) begin
				cnt_d[i] = '0;
			end else if (tick) begin
				if (cnt_q[i] == DB_CNT_W'(DB_TICKS - 1)) begin
					cnt_d[i] = '0;
					lvl_d[i] = raw_n[i];
				end else begin
					cnt_d[i] = cnt_q[i] + DB_CNT_W'(1);
				end
			end
		end
		case (sel)
			SEL_WAKE: obs_d = cnt_q[0][0];
			SEL_RING: obs_d = cnt_q[1][0];
			SEL_ADAPT: obs_d = cnt_q[2][0];
			SEL_WARM: obs_d = cnt_q[3][0];
			default: obs_d = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_q <= '0;
			lvl_q <= 4'hF;
			obs_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= '0;
			end
		end else begin
			presc_q <= presc_d;
			lvl_q <= lvl_d;
			obs_q <= obs_d;
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= cnt_d[i];
			end
		end
	end

	assign level_n = lvl_q;
	assign obs_bit = obs_q;
	assign presc_bit = presc_q[PRESC_W-1];
endmodule : pcct_debounce

// ---- rtl/pcct_pkg.sv ----
package pcct_pkg;
	localparam logic [31:0] ADDR_STATUS = 32'h8000_1024;
	localparam logic [31:0] ADDR_CLKCTL = 32'h8000_1028;
	localparam logic [31:0] ADDR_DBCT = 32'h8000_1030;
	localparam logic [31:0] ADDR_PLLTR = 32'h8000_1034;
	localparam logic [31:0] CLK_RESET = 32'h0000_2126;
	localparam logic [31:0] CLK_MASK = 32'h0000_FFFF;
	localparam int CC_COMMS_EN = 15;
	localparam int CC_LCD_EN = 14;
	localparam int CC_LCD_LSB = 8;
	localparam int CC_NOMUTE = 7;
	localparam int CC_IMMED = 6;
	localparam int CC_SYS_LSB = 0;
	localparam int FREQ_W = 6;
	localparam logic [5:0] FREQ_MIN = 6'h1B;
	localparam logic [5:0] FREQ_MAX = 6'h2D;
	localparam int DB_FORCE_CLK = 8;
	localparam int DB_OBS = 5;
	localparam int DB_NOBUSREQ = 4;
	localparam int DB_TEST = 3;
	localparam int DB_SEL_LSB = 0;
	localparam logic [31:0] DBCT_WMASK = 32'h0000_011F;
	localparam logic [31:0] DBCT_RMASK = 32'h0000_0017;
	localparam logic [2:0] SEL_WAKE = 3'h0;
	localparam logic [2:0] SEL_RING = 3'h1;
	localparam logic [2:0] SEL_ADAPT = 3'h3;
	localparam logic [2:0] SEL_WARM = 3'h4;
	localparam int ST_POR = 0;
	localparam int ST_LCD = 1;
	localparam int ST_COMMS = 2;
	localparam int ST_SYS = 3;
	localparam logic [31:0] ST_RESET = 32'h0000_000F;
	localparam logic [31:0] PLLTR_MASK = 32'h001F_FFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_HZ = 40_000_000;
	localparam int DB_TICK_HZ = 4_000;
	localparam int PRESC_CYCLES = CLK_HZ / DB_TICK_HZ;
	localparam int DB_TIME_MS = 16;
	localparam int DB_TICKS = DB_TIME_MS * DB_TICK_HZ / 1000;
	localparam int DB_CNT_W = 7;
	localparam int PRESC_W = 14;
	localparam logic [7:0] SYNC_RST = 8'hF8;

	function automatic logic pcct_code_ok(input logic [5:0] code);
		pcct_code_ok = (code >= FREQ_MIN) && (code <= FREQ_MAX);
	endfunction : pcct_code_ok

	function automatic logic [31:0] pcct_strb_mask(input logic [3:0] strb);
		pcct_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : pcct_strb_mask
endpackage : pcct_pkg

// ---- rtl/pcct_sync.sv ----
`timescale 1ns/1ps
module pcct_sync import pcct_pkg::*; #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Asynchronous in, synchronised out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule : pcct_sync

// ---- rtl/pcct_top.sv ----
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module pcct_top import pcct_pkg::*; #(
	parameter int PRESC = PRESC_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// PLL side
	input wire logic sys_pll_lock_detect,
	input wire logic lcd_pll_lock_detect,
	input wire logic comms_pll_lock_detect,
	output logic [5:0] sys_pll_freq,
	output logic [5:0] lcd_pll_freq,
	output logic lcd_pll_power_down,
	output logic comms_pll_power_down,
	// Clock gates
	output logic core_clock_enable,
	output logic bus_clock_enable,
	output logic lcd_clock_enable,
	output logic comms_clock_enable,
	// Pins and unit signals
	input wire logic warm_reset_pin_n,
	input wire logic wake_up_input_n,
	input wire logic ring_in_n,
	input wire logic adapter_ok_n,
	input wire logic test_pin_n,
	output logic test_mode_signal_n,
	output logic [3:0] debounced_events_n,
	input wire logic pmu_bus_req_in,
	output logic pmu_bus_request,
	output logic [20:0] pll_test_bits
);
	logic [7:0] pin_s;
	logic sys_lock_s, lcd_lock_s, comms_lock_s, warm_s, wake_s, ring_s, adapt_s, test_s;
	logic obs_bit, presc_bit;
	logic [31:0] ctrl_q, ctrl_d, dbct_q, dbct_d, status_q, status_d, plltr_q, plltr_d;
	logic [5:0] sys_freq_q, sys_freq_d, lcd_freq_q, lcd_freq_d;
	logic booted_q, booted_d, stop_q, stop_d;
	logic [2:0] lock_prev_q, lock_prev_d;
	logic core_en_q, core_en_d, lcd_en_q, lcd_en_d, comms_en_q, comms_en_d, test_n_q, test_n_d;
	logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic have_aw, have_w, do_wr, wr_ctrl, imm_wr, lock_fall;
	logic [31:0] wa, wd, wm;
	logic [2:0] fell;
	logic mute;

	// Lock detects come from free-running analogue blocks
	pcct_sync #(.W(8), .RST_VAL(SYNC_RST)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({test_pin_n, adapter_ok_n, ring_in_n, wake_up_input_n, warm_reset_pin_n,
			comms_pll_lock_detect, lcd_pll_lock_detect, sys_pll_lock_detect}),
		.sync_out(pin_s)
	);
	assign {test_s, adapt_s, ring_s, wake_s, warm_s, comms_lock_s, lcd_lock_s, sys_lock_s} = pin_s;

	pcct_debounce #(.PRESC(PRESC)) u_deb (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw_n({warm_s, adapt_s, ring_s, wake_s}),
		.trigger(dbct_q[DB_TEST]),
		.sel(dbct_q[DB_SEL_LSB +: 3]),
		.level_n(debounced_events_n),
		.obs_bit(obs_bit),
		.presc_bit(presc_bit)
	);

	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q && !bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		ctrl_d = ctrl_q;
		dbct_d = dbct_q;
		status_d = status_q;
		plltr_d = plltr_q;
		sys_freq_d = sys_freq_q;
		lcd_freq_d = lcd_freq_q;
		stop_d = stop_q;
		// Address and data may arrive in either order
		if (awvalid && awready) begin
			aw_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		have_aw = aw_q || (awvalid && awready);
		have_w = w_q || (wvalid && wready);
		do_wr = have_aw && have_w && !bvalid_q;
		wa = aw_q ? awaddr_q : awaddr;
		wd = w_q ? wdata_q : wdata;
		wm = pcct_strb_mask(w_q ? wstrb_q : wstrb);
		wr_ctrl = do_wr && (wa == ADDR_CLKCTL);
		if (do_wr) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			case (wa)
				ADDR_CLKCTL: ctrl_d = ((ctrl_q & ~wm) | (wd & wm)) & CLK_MASK;
				ADDR_DBCT: dbct_d = ((dbct_q & ~wm) | (wd & wm)) & DBCT_WMASK;
				ADDR_STATUS: status_d = status_q & ~(wd & wm & ST_RESET);
				ADDR_PLLTR: plltr_d = ((plltr_q & ~wm) | (wd & wm)) & PLLTR_MASK;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		imm_wr = wr_ctrl && wm[CC_SYS_LSB] && ctrl_d[CC_IMMED] && pcct_code_ok(ctrl_d[CC_SYS_LSB +: FREQ_W]);
		if (wr_ctrl && pcct_code_ok(ctrl_d[CC_LCD_LSB +: FREQ_W])) begin
			lcd_freq_d = ctrl_d[CC_LCD_LSB +: FREQ_W];
		end
		// Hardware sets outrank a same-cycle software clear
		lock_prev_d = {comms_lock_s, lcd_lock_s, sys_lock_s};
		fell = lock_prev_q & ~lock_prev_d;
		lock_fall = fell[0];
		if (fell[0]) begin
			status_d[ST_SYS] = 1'b1;
		end
		if (fell[1]) begin
			status_d[ST_LCD] = 1'b1;
		end
		if (fell[2]) begin
			status_d[ST_COMMS] = 1'b1;
		end
		if (!sys_lock_s) begin
			stop_d = 1'b0;
		end
		if (imm_wr) begin
			sys_freq_d = ctrl_d[CC_SYS_LSB +: FREQ_W];
			stop_d = !ctrl_d[CC_NOMUTE];
		end else if (lock_fall && pcct_code_ok(ctrl_q[CC_SYS_LSB +: FREQ_W])) begin
			sys_freq_d = ctrl_q[CC_SYS_LSB +: FREQ_W];
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			case (araddr)
				ADDR_CLKCTL: rdata_d = ctrl_q;
				ADDR_STATUS: rdata_d = status_q;
				ADDR_PLLTR: rdata_d = plltr_q;
				ADDR_DBCT: rdata_d = (dbct_q & DBCT_RMASK) | (32'(obs_bit) << DB_OBS) | (32'(presc_bit) << DB_TEST);
				default: begin
					rdata_d = '0;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	// Mute and gating decisions
	always_comb begin
		booted_d = booted_q;
		if (!warm_s) begin
			booted_d = 1'b0;
		end else if (sys_lock_s) begin
			booted_d = 1'b1;
		end
		mute = !booted_d || (!ctrl_d[CC_NOMUTE] && (!sys_lock_s || stop_d));
		core_en_d = dbct_d[DB_FORCE_CLK] || !mute;
		lcd_en_d = ctrl_d[CC_LCD_EN] && lcd_lock_s;
		comms_en_d = ctrl_d[CC_COMMS_EN] && comms_lock_s;
		test_n_d = !dbct_d[DB_TEST] && test_s;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CLK_RESET;
			dbct_q <= '0;
			status_q <= ST_RESET;
			plltr_q <= '0;
			sys_freq_q <= CLK_RESET[CC_SYS_LSB +: FREQ_W];
			lcd_freq_q <= CLK_RESET[CC_LCD_LSB +: FREQ_W];
			booted_q <= 1'b0;
			stop_q <= 1'b0;
			lock_prev_q <= '0;
			core_en_q <= 1'b0;
			lcd_en_q <= 1'b0;
			comms_en_q <= 1'b0;
			test_n_q <= 1'b1;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			ctrl_q <= ctrl_d;
			dbct_q <= dbct_d;
			status_q <= status_d;
			plltr_q <= plltr_d;
			sys_freq_q <= sys_freq_d;
			lcd_freq_q <= lcd_freq_d;
			booted_q <= booted_d;
			stop_q <= stop_d;
			lock_prev_q <= lock_prev_d;
			core_en_q <= core_en_d;
			lcd_en_q <= lcd_en_d;
			comms_en_q <= comms_en_d;
			test_n_q <= test_n_d;
			aw_q <= aw_d;
			w_q <= w_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign awready = !aw_q && !bvalid_q;
	assign wready = !w_q && !bvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign sys_pll_freq = sys_freq_q;
	assign lcd_pll_freq = lcd_freq_q;
	assign lcd_pll_power_down = !ctrl_q[CC_LCD_EN];
	assign comms_pll_power_down = !ctrl_q[CC_COMMS_EN];
	// One gate drives both; the bus clock is derived from the core clock
	assign core_clock_enable = core_en_q;
	assign bus_clock_enable = core_en_q;
	assign lcd_clock_enable = lcd_en_q;
	assign comms_clock_enable = comms_en_q;
	assign test_mode_signal_n = test_n_q;
	assign pmu_bus_request = pmu_bus_req_in && !dbct_q[DB_NOBUSREQ];
	assign pll_test_bits = plltr_q[20:0];

	a_reset_value: assert property (@(posedge aclk) $rose(aresetn) |-> ctrl_q == CLK_RESET)
		else $error("clock control reset value wrong");
	a_comms_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(!comms_lock_s)[*2] |-> !comms_clock_enable) else $error("comms clock ran without lock");
	a_lcd_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_q[CC_LCD_EN] || !$past(lcd_lock_s) |-> !lcd_clock_enable) else $error("lcd clock ran ungated");
	a_mute_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
		(!sys_lock_s && !ctrl_q[CC_NOMUTE] && !dbct_q[DB_FORCE_CLK])[*2] |-> !core_clock_enable)
		else $error("core clock not muted on unlock");
	a_nomute_run: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(sys_lock_s) && ctrl_q[CC_NOMUTE] && booted_q && warm_s && !wr_ctrl |=> core_clock_enable)
		else $error("core clock stopped despite no-mute");
	a_buffer_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(sys_pll_freq) |-> $past(lock_fall || imm_wr)) else $error("system code changed early");
	a_immed_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		imm_wr && !ctrl_d[CC_NOMUTE] && !dbct_d[DB_FORCE_CLK] |=> !core_clock_enable && !bus_clock_enable)
		else $error("clocks not stopped on immediate update");
	a_sys_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		sys_pll_freq >= FREQ_MIN && sys_pll_freq <= FREQ_MAX) else $error("system code out of range");
	a_lcd_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		lcd_pll_freq >= FREQ_MIN && lcd_pll_freq <= FREQ_MAX) else $error("lcd code out of range");
	a_force_clk: assert property (@(posedge aclk) disable iff (!aresetn)
		dbct_q[DB_FORCE_CLK] |-> core_clock_enable && bus_clock_enable) else $error("forced clocks off");
	a_bus_req_off: assert property (@(posedge aclk) disable iff (!aresetn)
		dbct_q[DB_NOBUSREQ] |-> !pmu_bus_request) else $error("bus request not blocked");
	a_test_force: assert property (@(posedge aclk) disable iff (!aresetn)
		dbct_q[DB_TEST] |-> !test_mode_signal_n) else $error("test mode not forced");
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(lcd_lock_s) |=> status_q[ST_LCD] ##1 status_q[ST_LCD] || $past(do_wr)) else $error("unlock flag lost");
	a_comms_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(comms_lock_s) |=> status_q[ST_COMMS]) else $error("comms unlock flag not set");
	c_imm_write: cover property (@(posedge aclk) disable iff (!aresetn) imm_wr);
	c_buf_apply: cover property (@(posedge aclk) disable iff (!aresetn) lock_fall && !ctrl_q[CC_IMMED]);
	c_force_clk: cover property (@(posedge aclk) disable iff (!aresetn) dbct_q[DB_FORCE_CLK] && !sys_lock_s);
	c_warm_mute: cover property (@(posedge aclk) disable iff (!aresetn) !warm_s && ctrl_q[CC_NOMUTE]);
	c_lcd_unlock: cover property (@(posedge aclk) disable iff (!aresetn) $fell(lcd_lock_s) && ctrl_q[CC_LCD_EN]);
endmodule : pcct_top

// ---- verification/pcct_pll_model.sv ----
`timescale 1ns/1ps
module pcct_pll_model #(
	parameter int LOCK_CYC = 20
) (
	// Clock
	input wire logic aclk,
	// Control from the block and the bench
	input wire logic power_down,
	input wire logic [5:0] freq,
	input wire logic force_unlock,
	// Lock indication
	output logic lock_detect
);
	int cnt_q = 0;
	logic [5:0] freq_q = 6'h00;
	initial lock_detect = 1'b0;
	// A new code throws the loop out of lock while the oscillator retunes
	always @(posedge aclk) begin
		freq_q <= freq;
		if (power_down || force_unlock || freq !== freq_q) begin
			cnt_q <= 0;
			lock_detect <= 1'b0;
		end else begin
			if (cnt_q < LOCK_CYC) cnt_q <= cnt_q + 1;
			lock_detect <= (cnt_q == LOCK_CYC);
		end
	end
endmodule : pcct_pll_model

// ---- verification/pcct_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module pcct_tb_top import pcct_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd_data;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic sys_lock, lcd_lock, comms_lock, sys_unlock = 1'b0, lcd_unlock = 1'b0, comms_unlock = 1'b0;
	logic [5:0] sys_pll_freq, lcd_pll_freq;
	logic lcd_pll_power_down, comms_pll_power_down;
	logic core_clock_enable, bus_clock_enable, lcd_clock_enable, comms_clock_enable;
	logic warm_reset_pin_n = 1'b1, wake_up_input_n = 1'b1, ring_in_n = 1'b1, adapter_ok_n = 1'b1;
	logic test_pin_n = 1'b1, pmu_bus_req_in = 1'b1;
	logic test_mode_signal_n, pmu_bus_request;
	logic [3:0] debounced_events_n;
	logic [20:0] pll_test_bits;
	logic [2:0] sels [4] = '{SEL_WAKE, SEL_RING, SEL_ADAPT, SEL_WARM};
	int fails = 0;
	int samples_checked = 0;

	always #12.5 aclk = ~aclk;

	// Short prescaler keeps the debounce waits within a few hundred cycles
	pcct_top #(.PRESC(8)) pcct_top_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sys_pll_lock_detect(sys_lock), .lcd_pll_lock_detect(lcd_lock), .comms_pll_lock_detect(comms_lock),
		.sys_pll_freq(sys_pll_freq), .lcd_pll_freq(lcd_pll_freq),
		.lcd_pll_power_down(lcd_pll_power_down), .comms_pll_power_down(comms_pll_power_down),
		.core_clock_enable(core_clock_enable), .bus_clock_enable(bus_clock_enable),
		.lcd_clock_enable(lcd_clock_enable), .comms_clock_enable(comms_clock_enable),
		.warm_reset_pin_n(warm_reset_pin_n), .wake_up_input_n(wake_up_input_n), .ring_in_n(ring_in_n),
		.adapter_ok_n(adapter_ok_n), .test_pin_n(test_pin_n), .test_mode_signal_n(test_mode_signal_n),
		.debounced_events_n(debounced_events_n), .pmu_bus_req_in(pmu_bus_req_in),
		.pmu_bus_request(pmu_bus_request), .pll_test_bits(pll_test_bits));

	pcct_pll_model sys_pll_model (.aclk(aclk), .power_down(1'b0), .freq(sys_pll_freq),
		.force_unlock(sys_unlock), .lock_detect(sys_lock));
	pcct_pll_model lcd_pll_model (.aclk(aclk), .power_down(lcd_pll_power_down), .freq(lcd_pll_freq),
		.force_unlock(lcd_unlock), .lock_detect(lcd_lock));
	pcct_pll_model comms_pll_model (.aclk(aclk), .power_down(comms_pll_power_down), .freq(6'h00),
		.force_unlock(comms_unlock), .lock_detect(comms_lock));

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	task automatic settle;
		@(negedge aclk);
	endtask : settle

	// Handshakes are judged at the negedge, where ready is stable until the next rising edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic aw_ok, w_ok, hs_a, hs_w, b_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			settle();
			hs_a = awvalid && awready;
			hs_w = wvalid && wready;
			@(posedge aclk);
			if (hs_a) awvalid <= 1'b0;
			if (hs_a) aw_ok = 1'b1;
			if (hs_w) wvalid <= 1'b0;
			if (hs_w) w_ok = 1'b1;
		end
		while (!b_ok) begin
			settle();
			b_ok = bvalid;
			resp = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		logic a_ok, r_ok;
		a_ok = 1'b0;
		r_ok = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!a_ok) begin
			settle();
			a_ok = arvalid && arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		while (!r_ok) begin
			settle();
			r_ok = rvalid;
			rd_data = rdata;
			resp = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask : rd

	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		`CHK(nm, e, rd_data & m)
		`CHK("read resp", RESP_OKAY, resp)
	endtask : rchk

	task automatic drop_sys(input int n);
		cyc(1);
		sys_unlock <= 1'b1;
		cyc(n);
		settle();
	endtask : drop_sys

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask : done

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	initial begin
		cyc(20000);
		fails++;
		$display("mismatch watchdog expected done seen timeout");
		results();
	end

	initial begin
		cyc(12);
		aresetn <= 1'b1;
		cyc(40);
		rchk("ctrl reset", ADDR_CLKCTL, 32'hFFFFFFFF, 32'h00002126);
		settle();
		`CHK("sys freq", 6'h26, sys_pll_freq)
		`CHK("lcd freq", 6'h21, lcd_pll_freq)
		`CHK("core en", 1'b1, core_clock_enable)
		`CHK("bus en", 1'b1, bus_clock_enable)
		rchk("status reset", ADDR_STATUS, 32'hFFFFFFFF, 32'h0000000F);
		wr(ADDR_STATUS, 32'h0000000F);
		rchk("status clr", ADDR_STATUS, 32'hFFFFFFFF, 32'h00000000);
		done("reset");
		wr(ADDR_CLKCTL, 32'h0000E026);
		settle();
		`CHK("lcd code", 6'h20, lcd_pll_freq)
		`CHK("pll power", 2'b00, {lcd_pll_power_down, comms_pll_power_down})
		`CHK("gated", 2'b00, {lcd_clock_enable, comms_clock_enable})
		cyc(40);
		settle();
		`CHK("ungated", 2'b11, {lcd_clock_enable, comms_clock_enable})
		cyc(1);
		lcd_unlock <= 1'b1;
		comms_unlock <= 1'b1;
		cyc(6);
		settle();
		`CHK("unlock gated", 2'b00, {lcd_clock_enable, comms_clock_enable})
		cyc(1);
		lcd_unlock <= 1'b0;
		comms_unlock <= 1'b0;
		rchk("pll flags", ADDR_STATUS, 32'h6, 32'h6);
		wr(ADDR_STATUS, 32'h00000006);
		rchk("pll flags clr", ADDR_STATUS, 32'h6, 32'h0);
		cyc(40);
		wr(ADDR_CLKCTL, 32'hFFFFFFFF);
		rchk("ctrl rsvd", ADDR_CLKCTL, 32'hFFFFFFFF, 32'h0000FFFF);
		settle();
		`CHK("sys rsvd code", 6'h26, sys_pll_freq)
		`CHK("lcd rsvd code", 6'h20, lcd_pll_freq)
		wr(ADDR_CLKCTL, 32'h00002126);
		cyc(4);
		settle();
		`CHK("pll off", 2'b11, {lcd_pll_power_down, comms_pll_power_down})
		`CHK("gated off", 2'b00, {lcd_clock_enable, comms_clock_enable})
		done("enables");
		wr(ADDR_CLKCTL, 32'h00002120);
		cyc(5);
		settle();
		`CHK("code held", 6'h26, sys_pll_freq)
		drop_sys(8);
		`CHK("muted", 1'b0, core_clock_enable)
		`CHK("code applied", 6'h20, sys_pll_freq)
		cyc(1);
		sys_unlock <= 1'b0;
		cyc(40);
		rchk("sys flag", ADDR_STATUS, 32'h8, 32'h8);
		wr(ADDR_STATUS, 32'h00000008);
		rchk("sys flag clr", ADDR_STATUS, 32'h8, 32'h0);
		settle();
		`CHK("relocked", 1'b1, core_clock_enable)
		done("buffered");
		wr(ADDR_CLKCTL, 32'h0000216D);
		settle();
		`CHK("immediate code", 6'h2D, sys_pll_freq)
		`CHK("core stop", 1'b0, core_clock_enable)
		`CHK("bus stop", 1'b0, bus_clock_enable)
		cyc(40);
		// Model relocks without overshoot, so no-mute is legal here
		wr(ADDR_CLKCTL, 32'h000021DB);
		settle();
		`CHK("low code", 6'h1B, sys_pll_freq)
		`CHK("no mute", 1'b1, core_clock_enable)
		cyc(8);
		settle();
		`CHK("no mute later", 1'b1, core_clock_enable)
		cyc(40);
		wr(ADDR_CLKCTL, 32'h00002166);
		cyc(40);
		done("immediate");
		wr(ADDR_DBCT, 32'h0000011C);
		settle();
		`CHK("forced test", 1'b0, test_mode_signal_n)
		`CHK("bus req off", 1'b0, pmu_bus_request)
		rchk("dbct", ADDR_DBCT, 32'hFFFFFFD7, 32'h00000014);
		drop_sys(8);
		`CHK("forced core", 1'b1, core_clock_enable)
		cyc(1);
		sys_unlock <= 1'b0;
		cyc(40);
		foreach (sels[i]) begin
			wr(ADDR_DBCT, {29'h0, sels[i]} | 32'h18);
			rchk("dbct sel", ADDR_DBCT, 32'h7, {29'h0, sels[i]});
		end
		cyc(1);
		wake_up_input_n <= 1'b0;
		ring_in_n <= 1'b0;
		adapter_ok_n <= 1'b0;
		cyc(40);
		settle();
		`CHK("not yet", 4'hF, debounced_events_n)
		cyc(40);
		settle();
		`CHK("debounced", 4'h8, debounced_events_n)
		cyc(1);
		wake_up_input_n <= 1'b1;
		ring_in_n <= 1'b1;
		adapter_ok_n <= 1'b1;
		cyc(80);
		wr(ADDR_DBCT, 32'h00000000);
		settle();
		`CHK("test pin high", 1'b1, test_mode_signal_n)
		`CHK("bus req on", 1'b1, pmu_bus_request)
		cyc(1);
		test_pin_n <= 1'b0;
		cyc(4);
		settle();
		`CHK("test pin low", 1'b0, test_mode_signal_n)
		cyc(1);
		test_pin_n <= 1'b1;
		done("test reg");
		wr(32'h80001040, 32'hFFFFFFFF);
		`CHK("unmapped wr", RESP_SLVERR, resp)
		rd(32'h80001040);
		`CHK("unmapped rd", RESP_SLVERR, resp)
		`CHK("unmapped data", 32'h0, rd_data)
		wr(ADDR_PLLTR, 32'hFFFFFFFF);
		rchk("pll test", ADDR_PLLTR, 32'hFFFFFFFF, 32'h001FFFFF);
		settle();
		`CHK("pll test bits", 21'h1FFFFF, pll_test_bits)
		wr(ADDR_CLKCTL, 32'h000021A6);
		cyc(1);
		warm_reset_pin_n <= 1'b0;
		cyc(6);
		settle();
		`CHK("warm mute", 1'b0, core_clock_enable)
		cyc(1);
		warm_reset_pin_n <= 1'b1;
		cyc(10);
		done("map and warm");
		results();
	end
endmodule : pcct_tb_top
